// ---- logic/mcu_exec_pkg.sv ----
// shared constants and types for the instruction subset executor
package mcu_exec_pkg;
    localparam int OPW = 14;
    localparam int DW = 8;
    localparam int FAW = 7;
    localparam int PCW = 12;
    localparam int PTRW = 16;
    localparam logic [13:0] OP_NOP = 14'h0000;
    localparam logic [13:0] OP_RET = 14'h0040;
    localparam logic [13:0] OP_INTERRUPT_RETURN_OP = 14'h0060;
    localparam logic [13:0] OP_SLEEP = 14'h0003;
    localparam logic [13:0] OP_TRDL = 14'h0050;
    localparam logic [13:0] OP_TRDH = 14'h0058;
    localparam logic [5:0] OPC_LITERAL_RETURN_OP = 6'h18;
    localparam logic [5:0] OPC_XORL = 6'h1f;
    localparam logic [5:0] OPC_RLF = 6'h0d;
    localparam logic [5:0] OPC_RRF = 6'h0c;
    localparam logic [5:0] OPC_SUB = 6'h02;
    localparam logic [5:0] OPC_SWAP = 6'h0e;
    localparam logic [5:0] OPC_ZERO_TEST_OP = 6'h08;
    localparam logic [5:0] OPC_XORF = 6'h06;
    localparam int DEST_BIT = 7;
    localparam int OPC_LSB = 8;
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [15:0] PTR_RESET = 16'h0000;

    typedef struct packed {
        logic carry;
        logic halfCarry;
        logic zero;
        logic timeout;
        logic powerdown;
    } status_t;

    typedef struct packed {
        logic we;
        logic [FAW-1:0] addr;
        logic [DW-1:0] data;
    } file_write_t;

    localparam status_t STATUS_RESET = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

    typedef enum logic [1:0] {
        EXEC = 2'b00,
        SECOND = 2'b01,
        HALTED = 2'b10
    } state_t;
endpackage : mcu_exec_pkg

// ---- logic/mcu_instruction_subset_exec.sv ----
// decode and execute of the return, rotate, subtract, swap, xor, sleep and
// table-read instructions
`timescale 1ns/1ns
`default_nettype none
module mcu_instruction_subset_exec (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [mcu_exec_pkg::OPW-1:0] instr,
    input wire logic instrValid,
    input wire logic wakeUp,
    input wire logic [mcu_exec_pkg::DW-1:0] fileReadData,
    input wire logic [mcu_exec_pkg::DW-1:0] pointerHighRegister,
    input wire logic [mcu_exec_pkg::DW-1:0] pointerLowRegister,
    input wire logic [mcu_exec_pkg::PCW-1:0] stackTopEntry,
    input wire logic [mcu_exec_pkg::OPW-1:0] romData,
    output logic [mcu_exec_pkg::FAW-1:0] fileReadAddr,
    output mcu_exec_pkg::file_write_t fileWrite,
    output logic pointerWrite,
    output logic [mcu_exec_pkg::PTRW-1:0] pointerNext,
    output logic [mcu_exec_pkg::PTRW-1:0] romAddr,
    output logic stackPop,
    output logic pcLoad,
    output logic [mcu_exec_pkg::PCW-1:0] pcLoadValue,
    output logic pcAdvance,
    output logic busy,
    output logic [mcu_exec_pkg::DW-1:0] workingRegister,
    output mcu_exec_pkg::status_t status,
    output logic globalInterruptEnable,
    output logic oscillatorStop
);
    import mcu_exec_pkg::*;

    // destination bit 1 leaves W alone, 0 sends the result into W
    function automatic logic [DW-1:0] routeW(input logic dest,
        input logic [DW-1:0] w, input logic [DW-1:0] res);
        routeW = dest ? w : res;
    endfunction : routeW

    function automatic logic opIs(input logic [OPW-1:0] word,
        input logic [5:0] code);
        opIs = (word[OPW-1:OPC_LSB] == code);
    endfunction : opIs

    function automatic logic zeroOf(input logic [DW-1:0] v);
        zeroOf = (v == 8'h00);
    endfunction : zeroOf

    function automatic logic [DW-1:0] rotateLeft(input logic [DW-1:0] v,
        input logic cin);
        rotateLeft = {v[DW-2:0], cin};
    endfunction : rotateLeft

    function automatic logic [DW-1:0] rotateRight(input logic [DW-1:0] v,
        input logic cin);
        rotateRight = {cin, v[DW-1:1]};
    endfunction : rotateRight

    function automatic logic [DW-1:0] swapNibbles(input logic [DW-1:0] v);
        swapNibbles = {v[3:0], v[7:4]};
    endfunction : swapNibbles

    // two's complement: f + ~w + 1, so a carry out means no borrow
    function automatic logic [DW:0] subtractWide(input logic [DW-1:0] f,
        input logic [DW-1:0] w);
        subtractWide = {1'b0, f} + {1'b0, ~w} + 9'h001;
    endfunction : subtractWide

    // same sum on the low nibble gives the half carry
    function automatic logic [4:0] subtractLow(input logic [3:0] f,
        input logic [3:0] w);
        subtractLow = {1'b0, f} + {1'b0, ~w} + 5'h01;
    endfunction : subtractLow

    state_t state;
    state_t next_state;
    status_t next_status;
    logic next_globalInterruptEnable;
    logic [DW-1:0] next_workingRegister;

    logic dest;
    logic [DW-1:0] fileVal;
    logic [DW-1:0] lit;
    logic [DW:0] diff;
    logic [4:0] lowDiff;
    logic [DW-1:0] aluRes;
    logic aluOp;
    logic writesFile;
    logic newZero;
    logic newCarry;
    logic newHalf;
    logic [PTRW-1:0] tablePtr;
    logic [DW-1:0] romLow;
    logic [DW-1:0] romHigh;

    // decoded strobes, one per supported opcode
    logic exec;
    logic isNop;
    logic isRet;
    logic isReti;
    logic isRetlw;
    logic isSleep;
    logic isTrdl;
    logic isTrdh;
    logic isTwoCycle;
    logic isRlf;
    logic isRrf;
    logic isSub;
    logic isSwap;
    logic isTestz;
    logic isXorl;
    logic isXorf;

    // nothing is taken while a two-cycle op finishes or the core is halted
    assign exec = (state == EXEC) && instrValid;
    assign dest = instr[DEST_BIT];
    assign fileReadAddr = instr[FAW-1:0];
    assign fileVal = fileReadData;
    assign lit = instr[DW-1:0];

    // whole-word opcodes
    assign isNop = exec && (instr == OP_NOP);
    assign isRet = exec && (instr == OP_RET);
    assign isReti = exec && (instr == OP_INTERRUPT_RETURN_OP);
    assign isSleep = exec && (instr == OP_SLEEP);
    assign isTrdl = exec && (instr == OP_TRDL);
    assign isTrdh = exec && (instr == OP_TRDH);
    // opcode field in the top six bits, operand below it
    assign isRetlw = exec && opIs(instr, OPC_LITERAL_RETURN_OP);
    assign isRlf = exec && opIs(instr, OPC_RLF);
    assign isRrf = exec && opIs(instr, OPC_RRF);
    assign isSub = exec && opIs(instr, OPC_SUB);
    assign isSwap = exec && opIs(instr, OPC_SWAP);
    assign isTestz = exec && opIs(instr, OPC_ZERO_TEST_OP) && dest;
    assign isXorl = exec && opIs(instr, OPC_XORL);
    assign isXorf = exec && opIs(instr, OPC_XORF);
    assign isTwoCycle = isRet || isReti || isRetlw
        || isTrdl || isTrdh;

    // a carry out of the subtract means that no borrow was needed
    assign diff = subtractWide(fileVal, workingRegister);
    assign lowDiff = subtractLow(fileVal[3:0], workingRegister[3:0]);
    assign newCarry = diff[DW];
    assign newHalf = lowDiff[4];

    assign aluOp = isRlf || isRrf || isSub || isSwap || isXorf;
    // register-operand results; the file value passes through otherwise
    always_comb begin
        aluRes = fileVal;
        if (isRlf) begin
            aluRes = rotateLeft(fileVal, status.carry);
        end else if (isRrf) begin
            aluRes = rotateRight(fileVal, status.carry);
        end else if (isSub) begin
            aluRes = diff[DW-1:0];
        end else if (isSwap) begin
            aluRes = swapNibbles(fileVal);
        end else if (isXorf) begin
            aluRes = fileVal ^ workingRegister;
        end
    end
    assign writesFile = aluOp && dest;
    assign newZero = isXorl ? zeroOf(workingRegister ^ lit)
        : zeroOf(aluRes);

    // the pointer pair lives outside; its value and its incremented value leave here
    assign tablePtr = {pointerHighRegister, pointerLowRegister};
    assign romAddr = tablePtr;
    assign romLow = romData[DW-1:0];
    assign romHigh = {2'b00, romData[OPW-1:DW]};
    assign pointerWrite = isTrdl;
    assign pointerNext = tablePtr + 16'h0001;

    // file write strobe is combinational so the register file updates on
    // the same edge as the working register
    assign fileWrite = '{
        we: writesFile,
        addr: fileReadAddr,
        data: aluRes
    };

    // every return pops and reloads the program counter from the stack top
    assign stackPop = isRet || isReti || isRetlw;
    assign pcLoad = stackPop;
    assign pcLoadValue = stackTopEntry;
    // nop, the table reads and every other op except the returns and sleep step the program counter
    assign pcAdvance = isNop || (exec && !stackPop && !isSleep);
    assign busy = (state != EXEC);
    assign oscillatorStop = (state == HALTED);

    // a two-cycle op blocks one request; power-down drops all until wake
    always_comb begin
        next_state = state;
        case (state)
            EXEC: begin
                if (isTwoCycle) begin
                    next_state = SECOND;
                end else if (isSleep) begin
                    next_state = HALTED;
                end
            end
            SECOND: begin
                next_state = EXEC;
            end
            HALTED: begin
                if (wakeUp) begin
                    next_state = EXEC;
                end
            end
            default: begin
                next_state = EXEC;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state <= EXEC;
        end else begin
            state <= next_state;
        end
    end

    // working register: table data is taken in the first cycle since the
    // pointer moves on the same edge
    always_comb begin
        next_workingRegister = workingRegister;
        if (isRetlw) begin
            next_workingRegister = lit;
        end else if (isXorl) begin
            next_workingRegister = workingRegister ^ lit;
        end else if (isTrdl) begin
            next_workingRegister = romLow;
        end else if (isTrdh) begin
            next_workingRegister = romHigh;
        end else if (aluOp) begin
            next_workingRegister = routeW(dest, workingRegister, aluRes);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            workingRegister <= W_RESET;
        end else begin
            workingRegister <= next_workingRegister;
        end
    end

    // each op touches only its own flags
    always_comb begin
        next_status = status;
        next_globalInterruptEnable = globalInterruptEnable;
        if (isRlf) begin
            next_status.carry = fileVal[DW-1];
        end else if (isRrf) begin
            next_status.carry = fileVal[0];
        end else if (isSub) begin
            next_status.carry = newCarry;
            next_status.halfCarry = newHalf;
            next_status.zero = newZero;
        end else if (isXorl || isXorf) begin
            next_status.zero = newZero;
        end else if (isTestz && zeroOf(fileVal)) begin
            // zero test only ever sets the flag, it never clears it
            next_status.zero = 1'b1;
        end else if (isSleep) begin
            next_status.timeout = 1'b1;
            next_status.powerdown = 1'b0;
        end
        if (isReti) begin
            next_globalInterruptEnable = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            status <= STATUS_RESET;
            globalInterruptEnable <= 1'b0;
        end else begin
            status <= next_status;
            globalInterruptEnable <= next_globalInterruptEnable;
        end
    end
endmodule : mcu_instruction_subset_exec
`default_nettype wire

// ---- tb/mcu_exec_asserts.sv ----
// port-level checker for the instruction subset executor
`timescale 1ns/1ns
`default_nettype none
module mcu_exec_asserts (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [13:0] instr,
    input wire logic instrValid,
    input wire logic busy,
    input wire logic stackPop,
    input wire logic [11:0] pcLoadValue,
    input wire logic [11:0] stackTopEntry,
    input wire logic globalInterruptEnable,
    input wire logic [7:0] workingRegister,
    input wire mcu_exec_pkg::status_t status,
    input wire logic oscillatorStop,
    input wire logic [15:0] romAddr,
    input wire logic [7:0] pointerHighRegister,
    input wire logic [7:0] pointerLowRegister,
    input wire logic pointerWrite
);
    import mcu_exec_pkg::*;
    wire logic take = instrValid && !busy;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    AST_RET_POP: assert property (take && instr == OP_RET
        |-> stackPop && pcLoadValue == stackTopEntry) else $error("no pop");
    AST_RET_TWO: assert property (take && instr == OP_RET
        |=> busy ##1 !busy) else $error("return length wrong");
    AST_INTERRUPT_RETURN_OP_GIE: assert property (take && instr == OP_INTERRUPT_RETURN_OP
        |=> globalInterruptEnable && busy) else $error("enable not set");
    AST_LITERAL_RETURN_OP: assert property (take && instr[13:8] == OPC_LITERAL_RETURN_OP
        |=> workingRegister == $past(instr[7:0]) && status == $past(status))
        else $error("literal return wrong");
    AST_SLEEP: assert property (take && instr == OP_SLEEP
        |=> oscillatorStop && status.timeout && !status.powerdown)
        else $error("power-down entry wrong");
    AST_XORL: assert property (take && instr[13:8] == OPC_XORL
        |=> workingRegister == ($past(workingRegister) ^ $past(instr[7:0]))
        && status.zero == (workingRegister == 8'h00)) else $error("xor wrong");
    AST_PTR: assert property (
        romAddr == {pointerHighRegister, pointerLowRegister})
        else $error("pointer order wrong");
    AST_TRDL: assert property (take && instr == OP_TRDL
        |-> pointerWrite ##1 busy ##1 !busy) else $error("table read wrong");
    cover property (take && instr == OP_TRDH);
    cover property (take && instr == OP_SLEEP);
    cover property (take && instr == OP_INTERRUPT_RETURN_OP);
endmodule : mcu_exec_asserts
bind mcu_instruction_subset_exec mcu_exec_asserts u_chk (.ref_clk, .reset_n,
    .instr, .instrValid, .busy, .stackPop, .pcLoadValue, .stackTopEntry,
    .globalInterruptEnable, .workingRegister, .status, .oscillatorStop,
    .romAddr, .pointerHighRegister, .pointerLowRegister, .pointerWrite);
`default_nettype wire

// ---- tb/mcu_exec_partner.sv ----
// register file, pointer pair, stack top and program memory model
`timescale 1ns/1ns
`default_nettype none
module mcu_exec_partner (
    input wire logic ref_clk,
    input wire logic [6:0] fileReadAddr,
    input wire mcu_exec_pkg::file_write_t fileWrite,
    input wire logic pointerWrite,
    input wire logic [15:0] pointerNext,
    input wire logic [15:0] romAddr,
    output logic [7:0] fileReadData,
    output logic [7:0] pointerHighRegister,
    output logic [7:0] pointerLowRegister,
    output logic [11:0] stackTopEntry,
    output logic [13:0] romData
);
    import mcu_exec_pkg::*;
    logic [7:0] mem [128];
    // each register starts holding its own address, so results are easy
    initial begin
        foreach (mem[i]) mem[i] = 8'(i);
        pointerHighRegister = 8'h02;
        pointerLowRegister = 8'h34;
    end
    assign fileReadData = mem[fileReadAddr];
    assign romData = romAddr[13:0] + 14'h3555;
    assign stackTopEntry = 12'h5a3;
    always @(posedge ref_clk) begin
        if (fileWrite.we) mem[fileWrite.addr] <= fileWrite.data;
        if (pointerWrite) begin
            {pointerHighRegister, pointerLowRegister} <= pointerNext;
        end
    end
endmodule : mcu_exec_partner
`default_nettype wire

// ---- tb/mcu_instruction_subset_exec_test.sv ----
// self-checking bench for the instruction subset executor
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module mcu_instruction_subset_exec_test;
    import mcu_exec_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic instrValid = 1'b0;
    logic wakeUp = 1'b0;
    logic [7:0] fileReadData, pointerHighRegister, pointerLowRegister;
    logic [7:0] workingRegister;
    logic [11:0] stackTopEntry, pcLoadValue;
    logic [13:0] romData;
    logic [6:0] fileReadAddr;
    file_write_t fileWrite;
    status_t status;
    logic [15:0] pointerNext, romAddr;
    logic pointerWrite, stackPop, busy, globalInterruptEnable, oscillatorStop;
    logic pcLoad, pcAdvance;
    logic sawPop, sawLoad, sawAdvance;
    int sawWait;
    int error_cnt = 0;
    int total_checks = 0;
    always #25 ref_clk = ~ref_clk;
    mcu_instruction_subset_exec u_dut (.ref_clk, .reset_n, .instr, .instrValid,
        .wakeUp, .fileReadData, .pointerHighRegister, .pointerLowRegister,
        .stackTopEntry, .romData, .fileReadAddr, .fileWrite, .pointerWrite,
        .pointerNext, .romAddr, .stackPop, .pcLoad, .pcLoadValue,
        .pcAdvance, .busy, .workingRegister, .status, .globalInterruptEnable,
        .oscillatorStop);
    mcu_exec_partner u_mem (.ref_clk, .fileReadAddr, .fileWrite, .pointerWrite,
        .pointerNext, .romAddr, .fileReadData, .pointerHighRegister,
        .pointerLowRegister, .stackTopEntry, .romData);
    // called at a falling edge; waits out the second cycle of long ops
    task run(input logic [13:0] op);
        int n;
        n = 0;
        instr = op;
        instrValid = 1'b1;
        // strobes stand only in the cycle of the request
        #1;
        sawPop = stackPop;
        sawLoad = pcLoad;
        sawAdvance = pcAdvance;
        @(negedge ref_clk);
        instrValid = 1'b0;
        while (busy === 1'b1 && n < 2) begin
            @(negedge ref_clk);
            n++;
        end
        sawWait = n;
    endtask : run
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    initial begin
        #(50 * 3000);
        $display("mismatch at %0t: watchdog expired", $time);
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (12) @(negedge ref_clk);
        reset_n = 1'b1;
        `CHK(workingRegister, W_RESET)
        `CHK(status, STATUS_RESET)
        run({OPC_XORL, 8'h5a}); `CHK(workingRegister, 8'h5a)
        run({OPC_XORL, 8'h5a}); `CHK(status.zero, 1'b1)
        run({OPC_XORL, 8'h02});
        run({OPC_SUB, 1'b1, 7'h03}); `CHK(u_mem.mem[3], 8'h01)
        `CHK(workingRegister, 8'h02)
        `CHK(status.carry, 1'b1)
        `CHK(status.halfCarry, 1'b1)
        `CHK(status.zero, 1'b0)
        run({OPC_SUB, 1'b0, 7'h01}); `CHK(workingRegister, 8'hff)
        `CHK(status.carry, 1'b0)
        `CHK(status.halfCarry, 1'b0)
        run({OPC_ZERO_TEST_OP, 1'b1, 7'h00}); `CHK(status.zero, 1'b1)
        run({OPC_RRF, 1'b0, 7'h41}); `CHK(workingRegister, 8'h20)
        `CHK(status.carry, 1'b1)
        `CHK(u_mem.mem[65], 8'h41)
        run({OPC_RLF, 1'b1, 7'h5a}); `CHK(u_mem.mem[90], 8'hb5)
        `CHK(status.carry, 1'b0)
        run({OPC_SWAP, 1'b0, 7'h5a}); `CHK(workingRegister, 8'h5b)
        run({OPC_XORF, 1'b1, 7'h10}); `CHK(u_mem.mem[16], 8'h4b)
        `CHK(status.zero, 1'b0)
        $display("test alu finished");
        run(OP_TRDH); `CHK(workingRegister, 8'h37)
        `CHK({pointerHighRegister, pointerLowRegister}, 16'h0234)
        run(OP_TRDL); `CHK(workingRegister, 8'h89)
        `CHK(sawWait, 1)
        `CHK({pointerHighRegister, pointerLowRegister}, 16'h0235)
        run(OP_TRDH); `CHK(workingRegister, 8'h37)
        run(OP_TRDL); `CHK(workingRegister, 8'h8a)
        $display("test table finished");
        run({OPC_LITERAL_RETURN_OP, 8'hc3}); `CHK(workingRegister, 8'hc3)
        `CHK(sawWait, 1)
        run(OP_INTERRUPT_RETURN_OP); `CHK(globalInterruptEnable, 1'b1)
        `CHK(sawPop, 1'b1)
        run(OP_RET); `CHK(sawPop, 1'b1)
        `CHK(sawLoad, 1'b1)
        `CHK(pcLoadValue, 12'h5a3)
        `CHK(sawWait, 1)
        run(OP_NOP); `CHK(workingRegister, 8'hc3)
        `CHK(sawAdvance, 1'b1)
        `CHK(sawPop, 1'b0)
        `CHK(sawWait, 0)
        run(OP_SLEEP); `CHK(oscillatorStop, 1'b1)
        `CHK(status.powerdown, 1'b0)
        // a request during power-down must be dropped
        run({OPC_XORL, 8'hff}); `CHK(workingRegister, 8'hc3)
        wakeUp = 1'b1;
        @(negedge ref_clk);
        wakeUp = 1'b0;
        @(negedge ref_clk);
        `CHK(busy, 1'b0)
        $display("test flow finished");
        stop_test();
    end
endmodule : mcu_instruction_subset_exec_test
`default_nettype wire
